// >>> hdl/eag_top.sv
`timescale 1ns/1ps
module eag_top (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic req_valid,
	input wire eag_pkg::eag_req_t req,
	input wire eag_pkg::eag_regs_t regs,
	output logic req_ready,
	output logic mem_req,
	output logic [23:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic res_valid,
	output eag_pkg::eag_res_t res
);
	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Zero extension of a displacement by size
	function automatic logic [23:0] eag_zext(input logic [31:0] f,
		input eag_pkg::eag_size_t s);
		unique case (s)
			eag_pkg::EAG_SZ8: eag_zext = {16'h0000, f[7:0]};
			eag_pkg::EAG_SZ16: eag_zext = {8'h00, f[15:0]};
			default: eag_zext = f[23:0];
		endcase
	endfunction

	// Sign extension of an 8- or 16-bit displacement
	function automatic logic [23:0] eag_sext(input logic [31:0] f,
		input eag_pkg::eag_size_t s);
		if (s == eag_pkg::EAG_SZ8)
			eag_sext = {{16{f[7]}}, f[7:0]};
		else
			eag_sext = {{8{f[15]}}, f[15:0]};
	endfunction

	// Indirect modes
	function automatic logic eag_is_ind(input eag_pkg::eag_mode_t m);
		eag_is_ind = (m == eag_pkg::EAG_ABS_SHORT_IND) || (m == eag_pkg::EAG_ABS_LONG_IND)
			|| (m == eag_pkg::EAG_AREG_IND2) || (m == eag_pkg::EAG_AREG_REL_IND)
			|| (m == eag_pkg::EAG_SB_REL_IND);
	endfunction

	// ----------------------------------------
	// Operand selection
	// ----------------------------------------
	logic [23:0] areg;
	logic [23:0] cur_sp;
	logic [23:0] disp_z;
	logic [23:0] disp_s;
	logic [23:0] sum_areg;
	logic [23:0] sum_sb;
	logic [23:0] sum_fb;
	logic [23:0] sum_sp;
	logic [23:0] sum_pc;
	logic [23:0] pc_disp;
	logic [23:0] short_base;
	logic [23:0] pc_base_sel;
	logic [23:0] abs_addr;
	logic is_short_jump;

	assign areg = req.areg_sel ? regs.addr_reg1 : regs.addr_reg0;
	// Flag low selects interrupt stack
	assign cur_sp = regs.stack_select_flag ? regs.user_stack_ptr : regs.interrupt_stack_ptr;
	assign disp_z = eag_zext(req.field, req.size);
	assign disp_s = eag_sext(req.field, req.size);
	// Short field limited to 16 bits
	assign abs_addr = (req.mode == eag_pkg::EAG_ABS_SHORT
		|| req.mode == eag_pkg::EAG_ABS_SHORT_IND)
		? (req.field[23:0] & eag_pkg::ABS_SHORT_MAX) : req.field[23:0];

	// Short jump: 3-bit unsigned from start+2
	assign is_short_jump = (req.op == eag_pkg::EAG_OP_JUMP) && (req.size == eag_pkg::EAG_SZ24);
	assign pc_disp = is_short_jump ? {21'h000000, req.field[2:0] & eag_pkg::SHORT_JUMP_MAX}
		: disp_s;
	assign pc_base_sel = is_short_jump ? short_base : req.pc_base;

	eag_adder u_short_base (
		.base(req.inst_addr),
		.disp(eag_pkg::PC_BASE_OFFSET),
		.sum(short_base)
	);
	// Address register relative
	eag_adder u_areg (
		.base(areg),
		.disp(disp_z),
		.sum(sum_areg)
	);
	// Static base relative, 8/16 only
	eag_adder u_sb (
		.base(regs.static_base_reg),
		.disp(req.size == eag_pkg::EAG_SZ8 ? disp_z : {8'h00, req.field[15:0]}),
		.sum(sum_sb)
	);
	// Frame base relative, signed
	eag_adder u_fb (
		.base(regs.frame_base_reg),
		.disp(disp_s),
		.sum(sum_fb)
	);
	// Stack relative, signed byte
	eag_adder u_sp (
		.base(cur_sp),
		.disp({{16{req.field[7]}}, req.field[7:0]}),
		.sum(sum_sp)
	);
	// Program counter relative
	eag_adder u_pc (
		.base(pc_base_sel),
		.disp(pc_disp),
		.sum(sum_pc)
	);

	// ----------------------------------------
	// Legality
	// ----------------------------------------
	logic ctrl_op;
	logic bad_ind;
	logic bad_ctrl;
	logic bad_sp;
	logic bad_pc;
	logic illegal;
	assign ctrl_op = (req.op == eag_pkg::EAG_OP_LOAD_CTRL) || (req.op == eag_pkg::EAG_OP_STORE_CTRL);
	// Long multiply/divide refuse indirect
	assign bad_ind = eag_is_ind(req.mode) && (req.op == eag_pkg::EAG_OP_LONG_MULDIV);
	// Control registers only for control ops
	assign bad_ctrl = (req.mode == eag_pkg::EAG_CTRL_REG) != ctrl_op;
	// Stack relative only for transfers
	assign bad_sp = (req.mode == eag_pkg::EAG_SP_REL) && (req.op != eag_pkg::EAG_OP_TRANSFER);
	// Call has no short form
	assign bad_pc = (req.mode == eag_pkg::EAG_PC_REL) && !((req.op == eag_pkg::EAG_OP_JUMP)
		|| (req.op == eag_pkg::EAG_OP_CALL && req.size != eag_pkg::EAG_SZ24));
	assign illegal = bad_ind || bad_ctrl || bad_sp || bad_pc;

	// ----------------------------------------
	// Direct effective address
	// ----------------------------------------
	logic [23:0] direct_ea;
	always_comb begin
		unique case (req.mode)
			eag_pkg::EAG_ABS_SHORT, eag_pkg::EAG_ABS_LONG,
			eag_pkg::EAG_ABS_SHORT_IND, eag_pkg::EAG_ABS_LONG_IND:
				direct_ea = abs_addr;
			eag_pkg::EAG_AREG_IND, eag_pkg::EAG_AREG_IND2:
				direct_ea = areg;
			eag_pkg::EAG_AREG_REL, eag_pkg::EAG_AREG_REL_IND:
				direct_ea = sum_areg;
			eag_pkg::EAG_SB_REL, eag_pkg::EAG_SB_REL_IND:
				direct_ea = sum_sb;
			eag_pkg::EAG_FB_REL: direct_ea = sum_fb;
			eag_pkg::EAG_SP_REL: direct_ea = sum_sp;
			eag_pkg::EAG_PC_REL: direct_ea = sum_pc;
			default: direct_ea = '0;
		endcase
	end

	// Control register: stack slot resolved by flag
	eag_pkg::eag_creg_t creg_res;
	assign creg_res = (req.creg_sel == eag_pkg::EAG_C_SP)
		? (regs.stack_select_flag ? eag_pkg::EAG_C_USP : eag_pkg::EAG_C_ISP) : req.creg_sel;

	// ----------------------------------------
	// Pointer fetch and result register
	// ----------------------------------------
	logic take;
	logic need_ptr;
	logic pf_done;
	logic [23:0] pf_ptr;
	logic busy;
	eag_pkg::eag_res_t next_res;
	eag_pkg::eag_res_t held;

	assign take = req_valid && req_ready;
	assign need_ptr = eag_is_ind(req.mode) && !illegal;

	eag_ptr_fetch u_fetch (
		.clock(clock),
		.rst_n(rst_n),
		.start(take && need_ptr),
		.ptr_addr(direct_ea),
		.mem_req(mem_req),
		.mem_addr(mem_addr),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata),
		.done(pf_done),
		.ptr(pf_ptr)
	);

	always_comb begin
		next_res = '0;
		next_res.illegal = illegal;
		next_res.reg_sel = req.reg_sel;
		next_res.creg_sel = creg_res;
		if (!illegal) begin
			unique case (req.mode)
				eag_pkg::EAG_LITERAL: begin
					// Constant cut to 8 or 16 bits by size, else passed whole
					next_res.is_literal = 1'b1;
					next_res.literal_operand = (req.size == eag_pkg::EAG_SZ8)
						? {24'h000000, req.field[7:0]}
						: (req.size == eag_pkg::EAG_SZ16) ? {16'h0000, req.field[15:0]}
						: req.field;
				end
				eag_pkg::EAG_REG_DIRECT: next_res.is_reg = 1'b1;
				eag_pkg::EAG_CTRL_REG: next_res.is_ctrl = 1'b1;
				default: begin
					next_res.is_mem = 1'b1;
					next_res.addr = direct_ea;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Handshake and output registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			req_ready <= 1'b0;
			res_valid <= 1'b0;
			res <= '0;
			held <= '0;
		end else begin
			res_valid <= 1'b0;
			if (take && need_ptr) begin
				// Hold decode while the pointer is read
				busy <= 1'b1;
				req_ready <= 1'b0;
				held <= next_res;
			end else if (take) begin
				res_valid <= 1'b1;
				res <= next_res;
			end else if (busy && pf_done) begin
				// Pointer's low 24 bits become address
				busy <= 1'b0;
				req_ready <= 1'b1;
				res_valid <= 1'b1;
				res <= held;
				res.addr <= pf_ptr;
			end else if (!busy) begin
				req_ready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_ptr_low24;
		@(posedge clock) disable iff (!rst_n)
		busy && pf_done |=> res_valid && res.addr == $past(mem_rdata[23:0], 2);
	endproperty
	a_ptr_low24: assert property (p_ptr_low24) else $error("pointer not used");

	property p_literal;
		@(posedge clock) disable iff (!rst_n)
		take && req.mode == eag_pkg::EAG_LITERAL && !illegal && req.size == eag_pkg::EAG_SZ32
		|=> res.is_literal && !res.is_mem && res.literal_operand == $past(req.field);
	endproperty
	a_literal: assert property (p_literal) else $error("literal wrong");

	property p_reg;
		@(posedge clock) disable iff (!rst_n)
		take && req.mode == eag_pkg::EAG_REG_DIRECT && !illegal |=> res.is_reg && !mem_req;
	endproperty
	a_reg: assert property (p_reg) else $error("register direct wrong");

	property p_areg_rel;
		@(posedge clock) disable iff (!rst_n)
		take && req.mode == eag_pkg::EAG_AREG_REL && !illegal
		|=> res.addr == 24'($past(areg) + $past(disp_z));
	endproperty
	a_areg_rel: assert property (p_areg_rel) else $error("register relative wrong");

	property p_fb;
		@(posedge clock) disable iff (!rst_n)
		take && req.mode == eag_pkg::EAG_FB_REL && !illegal
		|=> res.addr == 24'($past(regs.frame_base_reg) + $past(disp_s));
	endproperty
	a_fb: assert property (p_fb) else $error("frame relative wrong");

	property p_ind_refused;
		@(posedge clock) disable iff (!rst_n)
		take && eag_is_ind(req.mode) && req.op == eag_pkg::EAG_OP_LONG_MULDIV
		|=> res_valid && res.illegal ##1 !mem_req;
	endproperty
	a_ind_refused: assert property (p_ind_refused) else $error("indirect allowed");

	property p_ctrl;
		@(posedge clock) disable iff (!rst_n)
		take && req.mode == eag_pkg::EAG_CTRL_REG && !ctrl_op |=> res.illegal;
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control access allowed");

	property p_sp_sel;
		@(posedge clock) disable iff (!rst_n)
		take && req.mode == eag_pkg::EAG_CTRL_REG && ctrl_op && req.creg_sel == eag_pkg::EAG_C_SP
		|=> res.creg_sel == ($past(regs.stack_select_flag) ? eag_pkg::EAG_C_USP
			: eag_pkg::EAG_C_ISP);
	endproperty
	a_sp_sel: assert property (p_sp_sel) else $error("stack select wrong");

	property p_short_jump;
		@(posedge clock) disable iff (!rst_n)
		take && req.mode == eag_pkg::EAG_PC_REL && is_short_jump
		|=> res.addr == 24'($past(req.inst_addr) + eag_pkg::PC_BASE_OFFSET
			+ $past(req.field[2:0]));
	endproperty
	a_short_jump: assert property (p_short_jump) else $error("short jump wrong");

	c_literal: cover property (@(posedge clock) take && req.mode == eag_pkg::EAG_LITERAL);
	c_ind: cover property (@(posedge clock) busy && pf_done);
	c_wrap: cover property (@(posedge clock) take && req.mode == eag_pkg::EAG_FB_REL
		&& sum_fb > regs.frame_base_reg && disp_s[23]);
	c_pc: cover property (@(posedge clock) take && req.mode == eag_pkg::EAG_PC_REL);
endmodule

// >>> hdl/eag_pkg.sv
package eag_pkg;
	// Address space
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam logic [23:0] ABS_SHORT_MAX = 24'h00FFFF;
	localparam logic [23:0] ADDR_MAX = 24'hFFFFFF;
	localparam logic [23:0] PC_BASE_OFFSET = 24'h000002;
	localparam logic [2:0] SHORT_JUMP_MAX = 3'h7;

	// Operand specifier modes
	typedef enum logic [4:0] {
		EAG_LITERAL,
		EAG_REG_DIRECT,
		EAG_ABS_SHORT,
		EAG_ABS_LONG,
		EAG_AREG_IND,
		EAG_AREG_REL,
		EAG_SB_REL,
		EAG_FB_REL,
		EAG_SP_REL,
		EAG_ABS_SHORT_IND,
		EAG_ABS_LONG_IND,
		EAG_AREG_IND2,
		EAG_AREG_REL_IND,
		EAG_SB_REL_IND,
		EAG_CTRL_REG,
		EAG_PC_REL
	} eag_mode_t;

	// Displacement / literal size
	typedef enum logic [1:0] {
		EAG_SZ8,
		EAG_SZ16,
		EAG_SZ24,
		EAG_SZ32
	} eag_size_t;

	// Instruction class, for mode legality
	typedef enum logic [2:0] {
		EAG_OP_GENERIC,
		EAG_OP_TRANSFER,
		EAG_OP_LONG_MULDIV,
		EAG_OP_LOAD_CTRL,
		EAG_OP_STORE_CTRL,
		EAG_OP_JUMP,
		EAG_OP_CALL
	} eag_op_t;

	// Register direct selectors
	typedef enum logic [3:0] {
		EAG_R_D0L, EAG_R_D0H, EAG_R_D1L, EAG_R_D1H,
		EAG_R_D0, EAG_R_D1, EAG_R_D2, EAG_R_D3,
		EAG_R_A0, EAG_R_A1, EAG_R_PAIR_LO, EAG_R_PAIR_HI
	} eag_reg_t;

	// Control register selectors
	typedef enum logic [4:0] {
		EAG_C_VECTOR_BASE, EAG_C_ISP, EAG_C_SP, EAG_C_SB, EAG_C_FB,
		EAG_C_FLAG, EAG_C_SAVED_PC, EAG_C_VECTOR, EAG_C_SAVED_FLAG,
		EAG_C_DMA_MODE0, EAG_C_DMA_MODE1, EAG_C_DMA_CNT0, EAG_C_DMA_CNT1,
		EAG_C_DMA_RCNT0, EAG_C_DMA_RCNT1, EAG_C_DMA_MEM0, EAG_C_DMA_MEM1,
		EAG_C_DMA_SRC0, EAG_C_DMA_SRC1, EAG_C_DMA_RLD0, EAG_C_DMA_RLD1,
		EAG_C_USP
	} eag_creg_t;

	// Request from the decoder
	typedef struct packed {
		eag_mode_t mode;
		eag_size_t size;
		eag_op_t op;
		logic areg_sel;
		eag_reg_t reg_sel;
		eag_creg_t creg_sel;
		logic [31:0] field;
		logic [23:0] inst_addr;
		logic [23:0] pc_base;
	} eag_req_t;

	// Register file view
	typedef struct packed {
		logic [23:0] addr_reg0;
		logic [23:0] addr_reg1;
		logic [23:0] static_base_reg;
		logic [23:0] frame_base_reg;
		logic [23:0] interrupt_stack_ptr;
		logic [23:0] user_stack_ptr;
		logic stack_select_flag;
	} eag_regs_t;

	// Result to the memory access unit
	typedef struct packed {
		logic is_literal;
		logic is_reg;
		logic is_ctrl;
		logic is_mem;
		logic illegal;
		eag_reg_t reg_sel;
		eag_creg_t creg_sel;
		logic [31:0] literal_operand;
		logic [23:0] addr;
	} eag_res_t;
endpackage

// >>> hdl/eag_adder.sv
`timescale 1ns/1ps
// ----------------------------------------
// 24-bit address adder with wrap
// ----------------------------------------
module eag_adder (
	input wire logic [23:0] base,
	input wire logic [23:0] disp,
	output logic [23:0] sum
);
	// Carry beyond bit 23 is dropped, so both ends wrap
	logic [24:0] full;
	assign full = {1'b0, base} + {1'b0, disp};
	assign sum = full[23:0];
endmodule

// >>> hdl/eag_ptr_fetch.sv
`timescale 1ns/1ps
// ----------------------------------------
// Pointer fetch sequencer
// ----------------------------------------
module eag_ptr_fetch (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [23:0] ptr_addr,
	output logic mem_req,
	output logic [23:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic done,
	output logic [23:0] ptr
);
	// Idle, or waiting for the 4-byte read
	typedef enum logic {EAG_PF_IDLE, EAG_PF_WAIT} eag_pf_state_t;
	eag_pf_state_t state;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= EAG_PF_IDLE;
			mem_req <= 1'b0;
			mem_addr <= '0;
			done <= 1'b0;
			ptr <= '0;
		end else begin
			done <= 1'b0;
			unique case (state)
				EAG_PF_IDLE: begin
					if (start) begin
						state <= EAG_PF_WAIT;
						mem_req <= 1'b1;
						mem_addr <= ptr_addr;
					end
				end
				EAG_PF_WAIT: begin
					if (mem_ack) begin
						// Upper byte of pointer dropped
						state <= EAG_PF_IDLE;
						mem_req <= 1'b0;
						done <= 1'b1;
						ptr <= mem_rdata[23:0];
					end
				end
			endcase
		end
	end
endmodule

// >>> testbench/eag_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Memory access unit model for pointer reads
// ----------------------------------------
module eag_mem_model (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic mem_req,
	input wire logic [23:0] mem_addr,
	input wire logic [3:0] lag,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	// Wait counter since the request appeared
	logic [3:0] cnt;

	// Ack after lag cycles; data keeps toggling outside the ack cycle so a
	// late sample in the design never reads a stale pointer
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			mem_ack <= 1'b0;
			cnt <= 4'h0;
			mem_rdata <= 32'h00000000;
		end else if (mem_ack) begin
			// Single pulse, never two in a row
			mem_ack <= 1'b0;
			cnt <= 4'h0;
			mem_rdata <= ~mem_rdata;
		end else if (mem_req && cnt >= lag) begin
			// Upper byte is junk that the design must drop
			mem_ack <= 1'b1;
			mem_rdata <= {8'hC3, ~mem_addr};
		end else begin
			cnt <= mem_req ? cnt + 4'h1 : 4'h0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule

// >>> testbench/eag_tb_top.sv
`timescale 1ns/1ps
module eag_tb_top;
	// ----------------------------------------
	// Bench signals
	// ----------------------------------------
	logic clock, arst_n, req_valid, req_ready, mem_req, mem_ack, res_valid;
	logic [23:0] mem_addr;
	logic [23:0] mem_a; // Last pointer address seen
	logic [31:0] mem_rdata;
	logic [3:0] lag; // Memory model latency
	logic got_mem; // A pointer read was seen
	eag_pkg::eag_req_t req;
	eag_pkg::eag_regs_t regs;
	eag_pkg::eag_res_t res;
	int failures, total_checks, cycles;

	eag_top i_dut (.clock(clock), .arst_n(arst_n), .req_valid(req_valid), .req(req),
		.regs(regs), .req_ready(req_ready), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .res_valid(res_valid), .res(res));
	eag_mem_model i_mem (.clock(clock), .arst_n(arst_n), .mem_req(mem_req),
		.mem_addr(mem_addr), .lag(lag), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// A hang counts as a mismatch
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			summarize();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task summarize;
		if (failures == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One request; waits for the result and logs any pointer read
	task go(input eag_pkg::eag_mode_t m, input eag_pkg::eag_size_t s,
		input eag_pkg::eag_op_t o, input logic [31:0] f);
		req.mode = m;
		req.size = s;
		req.op = o;
		req.field = f;
		req_valid = 1'b1;
		while (req_ready !== 1'b1) begin
			@(posedge clock);
			#1;
		end
		@(posedge clock);
		#1;
		req_valid = 1'b0;
		got_mem = 1'b0;
		repeat (30) begin
			if (res_valid === 1'b1) break;
			if (mem_req === 1'b1) begin
				got_mem = 1'b1;
				mem_a = mem_addr;
			end
			@(posedge clock);
			#1;
		end
		// Let an idle cycle pass so req_valid is never set twice at once
		@(posedge clock);
		#1;
	endtask

	// Result kind flags, and no memory read for non-indirect modes
	task fl(input logic [4:0] f);
		check({27'h0, res.is_literal, res.is_reg, res.is_ctrl, res.is_mem, res.illegal}, {27'h0, f});
		check({31'h0, got_mem}, 32'h0);
	endtask

	task ea(input logic [4:0] f, input logic [23:0] a);
		fl(f);
		check({8'h00, res.addr}, {8'h00, a});
	endtask

	// Pointer read at the given place; result is its low 24 bits
	task ind(input logic [23:0] p);
		check({31'h0, got_mem}, 32'h1);
		check({8'h00, mem_a}, {8'h00, p});
		check({8'h00, res.addr}, {8'h00, ~p});
		check({31'h0, res.is_mem}, 32'h1);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		repeat (6) @(posedge clock);
		#1;
		check({31'h0, req_ready}, 32'h0);
		arst_n = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		check({31'h0, req_ready}, 32'h0);
		@(posedge clock);
		#1;
		check({31'h0, req_ready}, 32'h1);
	endtask

	task t_direct;
		go(eag_pkg::EAG_LITERAL, eag_pkg::EAG_SZ16, eag_pkg::EAG_OP_GENERIC, 32'hABCD1234);
		fl(5'h10);
		check(res.literal_operand, 32'h00001234);
		go(eag_pkg::EAG_LITERAL, eag_pkg::EAG_SZ32, eag_pkg::EAG_OP_GENERIC, 32'hABCD1234);
		check(res.literal_operand, 32'hABCD1234);
		req.reg_sel = eag_pkg::EAG_R_PAIR_HI;
		go(eag_pkg::EAG_REG_DIRECT, eag_pkg::EAG_SZ32, eag_pkg::EAG_OP_GENERIC, 32'h0);
		fl(5'h08);
		check({28'h0, res.reg_sel}, {28'h0, eag_pkg::EAG_R_PAIR_HI});
		go(eag_pkg::EAG_ABS_SHORT, eag_pkg::EAG_SZ16, eag_pkg::EAG_OP_GENERIC, 32'h00ABCDEF);
		ea(5'h02, 24'h00CDEF);
		go(eag_pkg::EAG_ABS_LONG, eag_pkg::EAG_SZ24, eag_pkg::EAG_OP_GENERIC, 32'h00ABCDEF);
		ea(5'h02, 24'hABCDEF);
	endtask

	// Address register and base offsets; each offset case but 8-bit frame base, which lands on zero, wraps past the top or below the bottom of the space
	task t_relative;
		req.areg_sel = 1'b1;
		go(eag_pkg::EAG_AREG_IND, eag_pkg::EAG_SZ8, eag_pkg::EAG_OP_GENERIC, 32'h0);
		ea(5'h02, 24'h001234);
		req.areg_sel = 1'b0;
		go(eag_pkg::EAG_AREG_REL, eag_pkg::EAG_SZ8, eag_pkg::EAG_OP_GENERIC, 32'h000000FF);
		ea(5'h02, 24'h0000EF);
		go(eag_pkg::EAG_AREG_REL, eag_pkg::EAG_SZ16, eag_pkg::EAG_OP_GENERIC, 32'hFFFF0020);
		ea(5'h02, 24'h000010);
		go(eag_pkg::EAG_AREG_REL, eag_pkg::EAG_SZ24, eag_pkg::EAG_OP_GENERIC, 32'h00000011);
		ea(5'h02, 24'h000001);
		go(eag_pkg::EAG_SB_REL, eag_pkg::EAG_SZ16, eag_pkg::EAG_OP_GENERIC, 32'h00000100);
		ea(5'h02, 24'h000080);
		go(eag_pkg::EAG_FB_REL, eag_pkg::EAG_SZ8, eag_pkg::EAG_OP_GENERIC, 32'h000000F0);
		ea(5'h02, 24'h000000);
		go(eag_pkg::EAG_FB_REL, eag_pkg::EAG_SZ16, eag_pkg::EAG_OP_GENERIC, 32'h0000FFE0);
		ea(5'h02, 24'hFFFFF0);
	endtask

	// Stack pointer chosen by the select flag, for memory and control use
	task t_stack;
		regs.stack_select_flag = 1'b0;
		go(eag_pkg::EAG_SP_REL, eag_pkg::EAG_SZ8, eag_pkg::EAG_OP_TRANSFER, 32'h000000F8);
		ea(5'h02, 24'hFFFFFC);
		req.creg_sel = eag_pkg::EAG_C_SP;
		go(eag_pkg::EAG_CTRL_REG, eag_pkg::EAG_SZ24, eag_pkg::EAG_OP_LOAD_CTRL, 32'h0);
		fl(5'h04);
		check({27'h0, res.creg_sel}, {27'h0, eag_pkg::EAG_C_ISP});
		regs.stack_select_flag = 1'b1;
		go(eag_pkg::EAG_SP_REL, eag_pkg::EAG_SZ8, eag_pkg::EAG_OP_TRANSFER, 32'h00000005);
		ea(5'h02, 24'h000003);
		go(eag_pkg::EAG_CTRL_REG, eag_pkg::EAG_SZ24, eag_pkg::EAG_OP_STORE_CTRL, 32'h0);
		check({27'h0, res.creg_sel}, {27'h0, eag_pkg::EAG_C_USP});
	endtask

	task t_pcrel;
		req.inst_addr = 24'hFFFFFE;
		go(eag_pkg::EAG_PC_REL, eag_pkg::EAG_SZ24, eag_pkg::EAG_OP_JUMP, 32'h00000007);
		check({8'h00, res.addr}, 32'h00000007);
		req.pc_base = 24'h000010;
		go(eag_pkg::EAG_PC_REL, eag_pkg::EAG_SZ8, eag_pkg::EAG_OP_JUMP, 32'h00000080);
		check({8'h00, res.addr}, 32'h00FFFF90);
		req.pc_base = 24'hFFFF00;
		go(eag_pkg::EAG_PC_REL, eag_pkg::EAG_SZ16, eag_pkg::EAG_OP_CALL, 32'h00007FFF);
		check({8'h00, res.addr}, 32'h00007EFF);
		check({31'h0, res.illegal}, 32'h0);
	endtask

	// Pointer fetch modes at the given memory latency
	task t_indirect(input logic [3:0] l);
		lag = l;
		go(eag_pkg::EAG_ABS_LONG_IND, eag_pkg::EAG_SZ24, eag_pkg::EAG_OP_GENERIC, 32'h00123456);
		ind(24'h123456);
		req.areg_sel = 1'b1;
		go(eag_pkg::EAG_AREG_IND2, eag_pkg::EAG_SZ8, eag_pkg::EAG_OP_GENERIC, 32'h0);
		ind(24'h001234);
		req.areg_sel = 1'b0;
		go(eag_pkg::EAG_AREG_REL_IND, eag_pkg::EAG_SZ8, eag_pkg::EAG_OP_GENERIC, 32'h00000020);
		ind(24'h000010);
		go(eag_pkg::EAG_SB_REL_IND, eag_pkg::EAG_SZ16, eag_pkg::EAG_OP_GENERIC, 32'h00000200);
		ind(24'h000180);
	endtask

	// Refused combinations: flagged illegal and no pointer read
	task t_illegal;
		go(eag_pkg::EAG_AREG_IND2, eag_pkg::EAG_SZ8, eag_pkg::EAG_OP_LONG_MULDIV, 32'h0);
		fl(5'h01);
		go(eag_pkg::EAG_CTRL_REG, eag_pkg::EAG_SZ24, eag_pkg::EAG_OP_GENERIC, 32'h0);
		fl(5'h01);
		go(eag_pkg::EAG_ABS_LONG, eag_pkg::EAG_SZ24, eag_pkg::EAG_OP_LOAD_CTRL, 32'h0);
		fl(5'h01);
		go(eag_pkg::EAG_SP_REL, eag_pkg::EAG_SZ8, eag_pkg::EAG_OP_GENERIC, 32'h0);
		fl(5'h01);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		arst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		lag = 4'h0;
		got_mem = 1'b0;
		mem_a = 24'h000000;
		regs = '{24'hFFFFF0, 24'h001234, 24'hFFFF80, 24'h000010, 24'h000004, 24'hFFFFFE, 1'b0};
		failures = 0;
		total_checks = 0;
		cycles = 0;
		t_reset();
		t_direct();
		t_relative();
		t_stack();
		t_pcrel();
		t_indirect(4'h0);
		t_indirect(4'h5);
		t_illegal();
		summarize();
	end
endmodule
